//--- hw/arpc_cache.sv
// Address-translation cache: lookup, learning from ARP traffic, aging
`timescale 1ns/100ps
`default_nettype none

// How it works
// - Each entry holds a 32-bit IP key and 48-bit MAC data, 80 bits.
// - Lookup presents an IP key; a matching entry returns its MAC.
// - Translation completes within 80 ns, independent of entry count.
// - A hit also outputs the matching entry index for external memory.
// - Entries are time-stamped and unused ones expire automatically.
// - Message fields: types 16 bits, lengths 8 bits, opcode 16, four addresses.
// - Protocol addresses are 32 bits, hardware addresses 48 bits.
// - Opcode 0001h marks a request, 0002h a reply.
module arpc_cache #(
	parameter int AGE_TICK = arpc_pkg::AGE_TICK_CYCLES
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic reset_n_in,
	// Lookup request
	input wire logic lookup_in,
	input wire logic [arpc_pkg::KEY_W-1:0] lookup_ip_in,
	// Received message for learning
	input wire logic msg_valid_in,
	input wire arpc_pkg::arpc_msg_t msg_in,
	// Lookup result
	output logic busy_out,
	output arpc_pkg::arpc_result_t result_out,
	// Learning report
	output logic learned_out,
	output logic is_request_out
);

	// ----------------------------------------
	// Constants and state
	// ----------------------------------------
	localparam int N = arpc_pkg::ENTRIES;
	localparam int IW = arpc_pkg::IDX_W;
	// Fixed latency: the compare and encode take the same cycles whatever the fill
	localparam logic [3:0] LAT = 4'(arpc_pkg::XLATE_CYCLES - 2);

	typedef struct packed {
		arpc_pkg::arpc_state_t st;
		logic [3:0] wait_cnt;
		logic [arpc_pkg::KEY_W-1:0] key;
		logic [arpc_pkg::TICK_W-1:0] tick_cnt;
		logic [IW-1:0] repl;
		logic busy;
		arpc_pkg::arpc_result_t res;
		logic learned;
		logic is_req;
	} arpc_cache_state_t;

	arpc_cache_state_t s_q;
	arpc_cache_state_t s_d;

	// ----------------------------------------
	// Slots
	// ----------------------------------------
	logic [N-1:0] match;
	logic [N-1:0] valid;
	logic [N-1:0] wr;
	logic [N-1:0] touch;
	arpc_pkg::arpc_entry_t entries [N];
	arpc_pkg::arpc_entry_t new_entry;
	logic [arpc_pkg::KEY_W-1:0] cmp_key;
	logic age_tick;

	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_slot
			arpc_slot u_slot (
				.clk_in(clk_in),
				.reset_n_in(reset_n_in),
				.write_in(wr[g]),
				.touch_in(touch[g]),
				.age_tick_in(age_tick),
				.entry_in(new_entry),
				.key_in(cmp_key),
				.match_out(match[g]),
				.valid_out(valid[g]),
				.entry_out(entries[g])
			);
		end
	endgenerate

	// ----------------------------------------
	// Match encode and learning decode
	// ----------------------------------------
	logic hit;
	logic [IW-1:0] hit_idx;
	logic msg_ok;
	logic msg_req;
	logic learn_hit;
	logic [IW-1:0] learn_idx;
	logic free_found;
	logic [IW-1:0] free_idx;
	logic [IW-1:0] wr_idx;

	// Sender address compare shares the key bus only when no lookup is running
	assign cmp_key = (s_q.st == arpc_pkg::ST_IDLE) ? msg_in.src_ip : s_q.key;

	always_comb begin
		hit = 1'b0;
		hit_idx = '0;
		free_found = 1'b0;
		free_idx = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (match[i]) begin
				hit = 1'b1;
				hit_idx = IW'(i);
			end
			if (!valid[i]) begin
				free_found = 1'b1;
				free_idx = IW'(i);
			end
		end
	end

	always_comb begin
		// Only IPv4-over-Ethernet sized messages are learned
		msg_ok = msg_valid_in
			&& (msg_in.hlen == arpc_pkg::HLEN_W'(arpc_pkg::DATA_W / 8))
			&& (msg_in.plen == arpc_pkg::PLEN_W'(arpc_pkg::KEY_W / 8))
			&& ((msg_in.oper == arpc_pkg::OPER_REQUEST)
			|| (msg_in.oper == arpc_pkg::OPER_REPLY));
		msg_req = msg_in.oper == arpc_pkg::OPER_REQUEST;
		learn_hit = hit && (s_q.st == arpc_pkg::ST_IDLE);
		learn_idx = hit_idx;
		// Refresh an existing mapping in place, else a free slot, else round robin
		wr_idx = learn_hit ? learn_idx : (free_found ? free_idx : s_q.repl);
		new_entry.ip = msg_in.src_ip;
		new_entry.mac = msg_in.src_mac;
	end

	// ----------------------------------------
	// Write and refresh strobes
	// ----------------------------------------
	// A message is dropped while a lookup owns the comparators or is being requested; the caller must hold off
	always_comb begin
		wr = '0;
		touch = '0;
		if (msg_ok && (s_q.st == arpc_pkg::ST_IDLE) && !lookup_in) begin
			wr[wr_idx] = 1'b1;
		end
		if ((s_q.st == arpc_pkg::ST_DONE) && hit) begin
			touch[hit_idx] = 1'b1;
		end
	end

	// One shared prescaler ages every slot on the same tick
	assign age_tick = s_q.tick_cnt == arpc_pkg::TICK_W'(AGE_TICK - 1);

	// ----------------------------------------
	// Lookup sequencing
	// ----------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.res.done = 1'b0;
		s_d.learned = 1'b0;
		s_d.tick_cnt = age_tick ? '0 : s_q.tick_cnt + 1'b1;
		if (|wr) begin
			s_d.learned = 1'b1;
			s_d.is_req = msg_req;
			if (!learn_hit && !free_found) begin
				s_d.repl = s_q.repl + 1'b1;
			end
		end
		case (s_q.st)
			arpc_pkg::ST_IDLE: begin
				if (lookup_in) begin
					s_d.key = lookup_ip_in;
					s_d.wait_cnt = LAT;
					s_d.busy = 1'b1;
					s_d.st = arpc_pkg::ST_WAIT;
				end
			end
			arpc_pkg::ST_WAIT: begin
				s_d.wait_cnt = s_q.wait_cnt - 1'b1;
				if (s_q.wait_cnt == 4'h1) begin
					s_d.st = arpc_pkg::ST_DONE;
				end
			end
			arpc_pkg::ST_DONE: begin
				s_d.res.done = 1'b1;
				s_d.res.hit = hit;
				s_d.res.miss = !hit;
				s_d.res.mac = hit ? entries[hit_idx].mac : '0;
				s_d.res.index = hit_idx;
				s_d.busy = 1'b0;
				s_d.st = arpc_pkg::ST_IDLE;
			end
			default: begin
				s_d.st = arpc_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// Every output leaves straight from the state register, no logic after it
	assign busy_out = s_q.busy;
	assign result_out = s_q.res;
	assign learned_out = s_q.learned;
	assign is_request_out = s_q.is_req;

endmodule
`default_nettype wire

//--- hw/arpc_pkg.sv
// Package for the address-translation cache: widths, timing and carrier structs
package arpc_pkg;

	// ----------------------------------------
	// Entry layout
	// ----------------------------------------
	localparam int ENTRY_W = 80;
	localparam int KEY_W = 32;
	localparam int DATA_W = 48;
	localparam int ENTRIES = 16;
	localparam int IDX_W = 4;

	// ----------------------------------------
	// Message field widths and operation codes
	// ----------------------------------------
	localparam int HTYPE_W = 16;
	localparam int PTYPE_W = 16;
	localparam int HLEN_W = 8;
	localparam int PLEN_W = 8;
	localparam int OPER_W = 16;
	localparam logic [OPER_W-1:0] OPER_REQUEST = 16'h0001;
	localparam logic [OPER_W-1:0] OPER_REPLY = 16'h0002;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_PS = 8000;
	localparam int XLATE_TIME_NS = 80;
	localparam int XLATE_CYCLES = (XLATE_TIME_NS * 1000) / CLK_PERIOD_PS;
	localparam int AGE_W = 2;
	localparam logic [AGE_W-1:0] AGE_FRESH = 2'h3;
	localparam logic [AGE_W-1:0] AGE_DEAD = 2'h0;
	localparam int TICK_W = 32;
	localparam int AGE_TICK_CYCLES = 125000000;

	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		logic [KEY_W-1:0] ip;
		logic [DATA_W-1:0] mac;
	} arpc_entry_t;

	typedef struct packed {
		logic [HTYPE_W-1:0] htype;
		logic [PTYPE_W-1:0] ptype;
		logic [HLEN_W-1:0] hlen;
		logic [PLEN_W-1:0] plen;
		logic [OPER_W-1:0] oper;
		logic [DATA_W-1:0] src_mac;
		logic [KEY_W-1:0] src_ip;
		logic [DATA_W-1:0] dst_mac;
		logic [KEY_W-1:0] dst_ip;
	} arpc_msg_t;

	typedef struct packed {
		logic done;
		logic hit;
		logic miss;
		logic [DATA_W-1:0] mac;
		logic [IDX_W-1:0] index;
	} arpc_result_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT = 2'b01,
		ST_DONE = 2'b10
	} arpc_state_t;

endpackage

//--- hw/arpc_slot.sv
// One cache slot: stored entry, valid bit, age counter and key comparator
`timescale 1ns/100ps
`default_nettype none

module arpc_slot (
	// Clock and reset
	input wire logic clk_in,
	input wire logic reset_n_in,
	// Control
	input wire logic write_in,
	input wire logic touch_in,
	input wire logic age_tick_in,
	input wire arpc_pkg::arpc_entry_t entry_in,
	input wire logic [arpc_pkg::KEY_W-1:0] key_in,
	// Status
	output logic match_out,
	output logic valid_out,
	output arpc_pkg::arpc_entry_t entry_out
);

	typedef struct packed {
		logic valid;
		logic [arpc_pkg::AGE_W-1:0] age;
		arpc_pkg::arpc_entry_t entry;
	} arpc_slot_state_t;

	arpc_slot_state_t s_q;
	arpc_slot_state_t s_d;

	always_comb begin
		s_d = s_q;
		if (write_in) begin
			s_d.valid = 1'b1;
			s_d.entry = entry_in;
			s_d.age = arpc_pkg::AGE_FRESH;
		end else if (touch_in) begin
			s_d.age = arpc_pkg::AGE_FRESH;
		end else if (age_tick_in && s_q.valid) begin
			// Stale entries drop out on their own, no outside sweep needed
			if (s_q.age == arpc_pkg::AGE_DEAD) begin
				s_d.valid = 1'b0;
			end else begin
				s_d.age = s_q.age - 1'b1;
			end
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign match_out = s_q.valid && (s_q.entry.ip == key_in);
	assign valid_out = s_q.valid;
	assign entry_out = s_q.entry;

endmodule
`default_nettype wire

//--- tb/arpc_cache_sva.sv
// Port checker for the address-translation cache
`timescale 1ns/100ps
`default_nettype none
module arpc_cache_sva #(parameter int AGE_TICK = 50) (
	// Clock, reset and requests
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic lookup_in,
	input wire logic [arpc_pkg::KEY_W-1:0] lookup_ip_in,
	input wire logic msg_valid_in,
	input wire arpc_pkg::arpc_msg_t msg_in,
	// Results
	input wire logic busy_out,
	input wire arpc_pkg::arpc_result_t result_out,
	input wire logic learned_out,
	input wire logic is_request_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);
	wire take = lookup_in && !busy_out;
	// A message in the done cycle is left out, though the engine is already idle in that cycle
	wire good = msg_valid_in && !lookup_in && !busy_out && !result_out.done
		&& msg_in.hlen == 8'h06 && msg_in.plen == 8'h04
		&& (msg_in.oper == arpc_pkg::OPER_REQUEST || msg_in.oper == arpc_pkg::OPER_REPLY);
	busy_hold_a: assert property (take |=> busy_out[*8])
		else $error("busy dropped early");
	done_lat_a: assert property (take |-> ##10 result_out.done && !busy_out)
		else $error("result not on time");
	one_answer_a: assert property (result_out.done |-> result_out.hit ^ result_out.miss)
		else $error("hit and miss disagree");
	miss_zero_a: assert property (result_out.done && result_out.miss |-> result_out.mac == '0)
		else $error("miss carries data");
	res_hold_a: assert property (!result_out.done |-> $stable(result_out[53:0]))
		else $error("result changed between answers");
	learn_take_a: assert property (good |=> learned_out)
		else $error("valid message not learned");
	learn_cause_a: assert property (learned_out |-> $past(msg_valid_in) && !$past(busy_out))
		else $error("learn without message");
	req_flag_a: assert property (learned_out |->
		is_request_out == ($past(msg_in.oper) == arpc_pkg::OPER_REQUEST))
		else $error("request flag wrong");
endmodule
`default_nettype wire

//--- tb/arpc_nic.sv
// Controller model: issues lookups and hands received messages to the cache
`timescale 1ns/100ps
`default_nettype none
module arpc_nic (
	// Clock and cache status
	input wire logic clk_in,
	input wire logic busy_in,
	input wire arpc_pkg::arpc_result_t res_in,
	input wire logic learned_in,
	input wire logic is_req_in,
	// Requests to the cache
	output logic look_out,
	output logic [31:0] ip_out,
	output logic msg_v_out,
	output arpc_pkg::arpc_msg_t msg_out
);
	initial begin
		look_out = 1'b0;
		ip_out = '0;
		msg_v_out = 1'b0;
		msg_out = '0;
	end
	// Released key is inverted so a stale value never looks valid
	task automatic lookup(input logic [31:0] ip, output arpc_pkg::arpc_result_t r, output int lat);
		@(negedge clk_in);
		while (busy_in) @(negedge clk_in);
		look_out = 1'b1;
		ip_out = ip;
		@(negedge clk_in);
		look_out = 1'b0;
		ip_out = ~ip;
		// The taking edge already lies behind this falling edge, so it counts
		lat = 1;
		do begin
			@(negedge clk_in);
			lat++;
		end while (res_in.done !== 1'b1 && lat < 20);
		r = res_in;
	endtask
	task automatic send(input logic [15:0] op, input logic [7:0] hl, input logic [31:0] ip,
		input logic [47:0] mac, input logic [31:0] dst, output logic l, output logic q);
		@(negedge clk_in);
		msg_out = {16'h0001, 16'h0800, hl, 8'h04, op, mac, ip, 48'h0, dst};
		msg_v_out = 1'b1;
		@(negedge clk_in);
		// The learn pulse stands only in the cycle after the taking edge
		l = learned_in;
		q = is_req_in;
		msg_v_out = 1'b0;
		msg_out = ~msg_out;
	endtask
	// On a miss the request goes out on the wire; only its reply reaches the cache
	task automatic resolve(input logic [31:0] ip, input logic [47:0] mac,
		output arpc_pkg::arpc_result_t r, output int lat, output logic l, output logic q);
		lookup(ip, r, lat);
		l = 1'b0;
		q = 1'b0;
		if (r.miss) send(arpc_pkg::OPER_REPLY, 8'h06, ip, mac, 32'h0a000001, l, q);
	endtask
endmodule
`default_nettype wire

//--- tb/arpc_cache_tb.sv
// Self-checking bench for the address-translation cache
`timescale 1ns/100ps
`default_nettype none
module arpc_cache_tb;
	logic clk_in = 1'b0;
	logic reset_n_in = 1'b0;
	logic lookup_in, msg_valid_in, busy_out, learned_out, is_request_out;
	logic [31:0] lookup_ip_in;
	arpc_pkg::arpc_msg_t msg_in;
	arpc_pkg::arpc_result_t result_out;
	int err_total = 0;
	int samples_checked = 0;
	int cyc = 0;
	logic [31:0] m_ip [16];
	logic [47:0] m_mac [16];
	int m_n = 0;
	int m_rr = 0;
	always #4 clk_in = ~clk_in;
	arpc_cache #(.AGE_TICK(50)) DUT (.clk_in(clk_in), .reset_n_in(reset_n_in),
		.lookup_in(lookup_in), .lookup_ip_in(lookup_ip_in), .msg_valid_in(msg_valid_in),
		.msg_in(msg_in), .busy_out(busy_out), .result_out(result_out),
		.learned_out(learned_out), .is_request_out(is_request_out));
	arpc_nic nic (.clk_in(clk_in), .busy_in(busy_out), .res_in(result_out),
		.learned_in(learned_out), .is_req_in(is_request_out), .look_out(lookup_in),
		.ip_out(lookup_ip_in), .msg_v_out(msg_valid_in), .msg_out(msg_in));
	// ----
	// Reference model: slots filled lowest first, same key rewritten in place, then round robin
	// ----
	function automatic void learn(input logic [31:0] ip, input logic [47:0] mac);
		int k = m_n;
		for (int i = 0; i < m_n; i++) if (m_ip[i] === ip) k = i;
		if (k == 16) begin
			k = m_rr;
			m_rr = (m_rr + 1) % 16;
		end
		m_ip[k] = ip;
		m_mac[k] = mac;
		if (k == m_n) m_n++;
	endfunction
	task automatic chk_res(input logic [31:0] ip, input arpc_pkg::arpc_result_t r, input int lat);
		int k = -1;
		for (int i = 0; i < m_n; i++) if (m_ip[i] === ip) k = i;
		samples_checked++;
		if (lat != arpc_pkg::XLATE_CYCLES || r.hit !== (k >= 0) || r.miss !== (k < 0)
			|| r.mac !== (k >= 0 ? m_mac[k] : 48'h0) || (k >= 0 && r.index !== k[3:0])) begin
			err_total++;
			$display("[ERR] %0t lookup mismatch", $time);
		end
	endtask
	task automatic chk_lrn(input logic l, input logic q, input logic el, input logic eq);
		samples_checked++;
		if (l !== el || (el && q !== eq)) begin
			err_total++;
			$display("[ERR] %0t learn mismatch", $time);
		end
	endtask
	task automatic tally_and_finish();
		if (err_total == 0 && samples_checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			err_total++;
			$display("[ERR] %0t timeout", $time);
			tally_and_finish();
		end
	end
	initial begin
		arpc_pkg::arpc_result_t r;
		logic l, q;
		int lat;
		logic [31:0] ip;
		logic [47:0] mac;
		logic [31:0] first_ip;
		void'($urandom(32'h5487));
		repeat (5) @(negedge clk_in);
		reset_n_in = 1'b1;
		ip = $urandom();
		mac = 48'({$urandom(), $urandom()});
		nic.resolve(ip, mac, r, lat, l, q);
		chk_res(ip, r, lat);
		chk_lrn(l, q, 1'b1, 1'b0);
		learn(ip, mac);
		for (int i = 0; i < 6; i++) begin
			ip = $urandom();
			mac = 48'({$urandom(), $urandom()});
			nic.send(arpc_pkg::OPER_REQUEST, 8'h06, ip, mac, ~ip, l, q);
			chk_lrn(l, q, 1'b1, 1'b1);
			learn(ip, mac);
		end
		mac = ~mac;
		nic.send(arpc_pkg::OPER_REPLY, 8'h06, ip, mac, 32'h0, l, q);
		chk_lrn(l, q, 1'b1, 1'b0);
		learn(ip, mac);
		ip = $urandom();
		nic.send(arpc_pkg::OPER_REPLY, 8'h08, ip, mac, 32'h0, l, q);
		chk_lrn(l, q, 1'b0, 1'b0);
		nic.send(16'h0003, 8'h06, ip, mac, 32'h0, l, q);
		chk_lrn(l, q, 1'b0, 1'b0);
		nic.lookup(ip, r, lat);
		chk_res(ip, r, lat);
		for (int i = 0; i < m_n; i++) begin
			nic.lookup(m_ip[i], r, lat);
			chk_res(m_ip[i], r, lat);
		end
		// Idle well past the longest entry life so every slot expires
		repeat (400) @(negedge clk_in);
		ip = m_ip[0];
		m_n = 0;
		nic.lookup(ip, r, lat);
		chk_res(ip, r, lat);
		// Seventeen new senders: the last one evicts the first slot round robin
		for (int i = 0; i < 17; i++) begin
			ip = $urandom();
			if (i == 0) first_ip = ip;
			mac = 48'({$urandom(), $urandom()});
			nic.send(arpc_pkg::OPER_REPLY, 8'h06, ip, mac, 32'h0, l, q);
			chk_lrn(l, q, 1'b1, 1'b0);
			learn(ip, mac);
		end
		nic.lookup(first_ip, r, lat);
		chk_res(first_ip, r, lat);
		nic.lookup(ip, r, lat);
		chk_res(ip, r, lat);
		tally_and_finish();
	end
endmodule
bind arpc_cache arpc_cache_sva #(.AGE_TICK(AGE_TICK)) u_sva (.clk_in(clk_in),
	.reset_n_in(reset_n_in), .lookup_in(lookup_in), .lookup_ip_in(lookup_ip_in),
	.msg_valid_in(msg_valid_in), .msg_in(msg_in), .busy_out(busy_out),
	.result_out(result_out), .learned_out(learned_out), .is_request_out(is_request_out));
`default_nettype wire
